// ### logic/mcbl_consts.vh
// Purpose: Shared constants for the microcore branch and load execution unit.
// Assumes: 16-bit instruction words, 10-bit code addresses.
// Notes: Opcode patterns are compared against masked instruction words.
`ifndef MCBL_CONSTS_VH
`define MCBL_CONSTS_VH

// ----------------------------------------------------------------------------
// Status register offsets
// ----------------------------------------------------------------------------
`define MCBL_CORE0_STATUS_A 9'h105
`define MCBL_CORE1_STATUS_A 9'h106
`define MCBL_CORE0_STATUS_B 9'h125
`define MCBL_CORE1_STATUS_B 9'h126
`define MCBL_CORE0_STATUS_C 9'h145
`define MCBL_CORE1_STATUS_C 9'h146
`define MCBL_STATUS_RESET 16'h0000

// ----------------------------------------------------------------------------
// Opcode masks and patterns
// ----------------------------------------------------------------------------
`define MCBL_JSRR_MASK 16'hFC00
`define MCBL_JSRR_PAT 16'h3000
`define MCBL_JTSF_MASK 16'hFFF7
`define MCBL_JTSF_PAT 16'h39B5
`define MCBL_JTSR_MASK 16'hFFE0
`define MCBL_JTSR_PAT 16'h2F20
`define MCBL_LDCA_MASK 16'hE007
`define MCBL_LDCA_PAT 16'hA004
`define MCBL_LDCD_MASK 16'hC000
`define MCBL_LDCD_PAT 16'hC000
`define MCBL_LDIRH_MASK 16'hF803
`define MCBL_LDIRH_PAT 16'h3803
`define MCBL_LDIRL_MASK 16'hF803
`define MCBL_LDIRL_PAT 16'h3802

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define MCBL_DEST_MSB 4
`define MCBL_POL_BIT 9
`define MCBL_STATUS_BIT_SELECT_MSB 8
`define MCBL_STATUS_BIT_SELECT_LSB 5
`define MCBL_JREG_BIT 3
`define MCBL_LDCA_RST_BIT 12
`define MCBL_LDCD_RST_BIT 13
`define MCBL_LDCD_OFS_BIT 12
`define MCBL_SH1_MSB 11
`define MCBL_SH1_LSB 10
`define MCBL_SH2_MSB 9
`define MCBL_SH2_LSB 8
`define MCBL_LDCA_EOC_MSB 7
`define MCBL_LDCA_EOC_LSB 6
`define MCBL_LDCD_DRAM_MSB 7
`define MCBL_LDCD_DRAM_LSB 2
`define MCBL_LDCD_EOC_MSB 1
`define MCBL_LDCD_EOC_LSB 0
`define MCBL_IRB_CLR_BIT 10
`define MCBL_IRB_MSB 9
`define MCBL_IRB_LSB 2

// ----------------------------------------------------------------------------
// Shortcut codes
// ----------------------------------------------------------------------------
`define MCBL_SC_KEEP 2'h0
`define MCBL_SC_OFF 2'h1
`define MCBL_SC_ON 2'h2
`define MCBL_SC_TOGGLE 2'h3

`endif

// ### logic/mcbl_exec.v
// Purpose: Executes relative status branches, subroutine calls, count-limit
//   loads and immediate byte loads for one microcore.
// Assumes: The fetch side presents one instruction with instr_valid and holds
//   it while stall_ff is high. Data RAM answers in the same cycle as dram_rd_ff.
// Notes: Unrecognised instructions simply advance the program counter.
`timescale 1ns/1ps
`include "mcbl_consts.vh"

module mcbl_exec #(
  parameter PC_W = 10,
  parameter DATA_W = 16,
  parameter DRAM_W = 6
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Instruction issue
  input wire instr_valid,
  input wire [15:0] instr,
  input wire core_sel,
  output reg stall_ff,
  output reg [PC_W-1:0] micro_program_counter_ff,
  output reg [PC_W-1:0] return_address_ff,
  // Operand sources
  input wire [PC_W-1:0] jump_target_reg_a,
  input wire [PC_W-1:0] jump_target_reg_b,
  input wire [DATA_W-1:0] source_operand,
  input wire [DRAM_W-1:0] index_base,
  // Data RAM read port
  output reg dram_rd_ff,
  output reg [DRAM_W-1:0] dram_addr_ff,
  input wire [DATA_W-1:0] dram_rdata,
  // Count limits and counter clears
  output reg [DATA_W-1:0] count_limit_1_ff,
  output reg [DATA_W-1:0] count_limit_2_ff,
  output reg [DATA_W-1:0] count_limit_3_ff,
  output reg [DATA_W-1:0] count_limit_4_ff,
  output reg [3:0] count_clear_ff,
  // Output diagnosis shortcuts
  output reg output_link_a_ff,
  output reg output_link_b_ff,
  // Immediate register
  output reg [DATA_W-1:0] immediate_word_ff,
  // Status register port
  input wire [8:0] reg_addr,
  input wire reg_wr,
  input wire [DATA_W-1:0] reg_wdata,
  output reg [DATA_W-1:0] reg_rdata_ff
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  function [PC_W-1:0] rel_target;
    input [PC_W-1:0] base;
    input [4:0] ofs;
    begin
      rel_target = base + {{(PC_W-5){ofs[4]}}, ofs};
    end
  endfunction

  function shortcut;
    input cur;
    input [1:0] code;
    begin
      case (code)
        `MCBL_SC_KEEP: shortcut = cur;
        `MCBL_SC_OFF: shortcut = 1'b0;
        `MCBL_SC_ON: shortcut = 1'b1;
        `MCBL_SC_TOGGLE: shortcut = ~cur;
        default: shortcut = cur;
      endcase
    end
  endfunction

  function is_op;
    input [15:0] word;
    input [15:0] mask;
    input [15:0] pat;
    begin
      is_op = (word & mask) == pat;
    end
  endfunction

  // --------------------------------------------------------------------------
  // State and decode
  // --------------------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  reg state_ff;
  reg nxt_state;
  reg [1:0] pend_eoc_ff;
  reg [1:0] nxt_pend_eoc;
  reg pend_rst_ff;
  reg nxt_pend_rst;
  reg [DATA_W-1:0] status0_ff;
  reg [DATA_W-1:0] status1_ff;

  reg [PC_W-1:0] nxt_pc;
  reg [PC_W-1:0] nxt_ret;
  reg nxt_stall;
  reg nxt_dram_rd;
  reg [DRAM_W-1:0] nxt_dram_addr;
  reg [DATA_W-1:0] nxt_lim1;
  reg [DATA_W-1:0] nxt_lim2;
  reg [DATA_W-1:0] nxt_lim3;
  reg [DATA_W-1:0] nxt_lim4;
  reg [3:0] nxt_clear;
  reg nxt_link_a;
  reg nxt_link_b;
  reg [DATA_W-1:0] nxt_imm;
  reg [DATA_W-1:0] nxt_rdata;

  wire take = instr_valid && (state_ff == ST_IDLE);
  wire [DATA_W-1:0] cur_status = core_sel ? status1_ff : status0_ff;
  wire sel_bit = cur_status[instr[`MCBL_STATUS_BIT_SELECT_MSB:`MCBL_STATUS_BIT_SELECT_LSB]];
  wire cond_true = (sel_bit == instr[`MCBL_POL_BIT]);
  wire [4:0] dest = instr[`MCBL_DEST_MSB:0];
  wire [PC_W-1:0] pc_next = micro_program_counter_ff + {{(PC_W-1){1'b0}}, 1'b1};
  wire [DRAM_W-1:0] dram_field = instr[`MCBL_LDCD_DRAM_MSB:`MCBL_LDCD_DRAM_LSB];
  wire [7:0] byte_operand = instr[`MCBL_IRB_MSB:`MCBL_IRB_LSB];
  wire clr_other = instr[`MCBL_IRB_CLR_BIT];

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    nxt_pend_eoc = pend_eoc_ff;
    nxt_pend_rst = pend_rst_ff;
    nxt_pc = micro_program_counter_ff;
    nxt_ret = return_address_ff;
    nxt_stall = 1'b0;
    nxt_dram_rd = 1'b0;
    nxt_dram_addr = dram_addr_ff;
    nxt_lim1 = count_limit_1_ff;
    nxt_lim2 = count_limit_2_ff;
    nxt_lim3 = count_limit_3_ff;
    nxt_lim4 = count_limit_4_ff;
    nxt_clear = 4'h0;
    nxt_link_a = output_link_a_ff;
    nxt_link_b = output_link_b_ff;
    nxt_imm = immediate_word_ff;
    case (state_ff)
      ST_IDLE: begin
        if (take) begin
          nxt_pc = pc_next;
          if (is_op(instr, `MCBL_JSRR_MASK, `MCBL_JSRR_PAT)) begin
            if (cond_true) begin
              nxt_pc = rel_target(micro_program_counter_ff, dest);
            end else begin
              nxt_pc = pc_next;
            end
          end else if (is_op(instr, `MCBL_JTSF_MASK, `MCBL_JTSF_PAT)) begin
            nxt_ret = micro_program_counter_ff;
            nxt_pc = instr[`MCBL_JREG_BIT] ? jump_target_reg_b : jump_target_reg_a;
          end else if (is_op(instr, `MCBL_JTSR_MASK, `MCBL_JTSR_PAT)) begin
            nxt_ret = micro_program_counter_ff;
            nxt_pc = rel_target(micro_program_counter_ff, dest);
          end else if (is_op(instr, `MCBL_LDCA_MASK, `MCBL_LDCA_PAT)) begin
            case (instr[`MCBL_LDCA_EOC_MSB:`MCBL_LDCA_EOC_LSB])
              2'h0: nxt_lim1 = source_operand;
              2'h1: nxt_lim2 = source_operand;
              2'h2: nxt_lim3 = source_operand;
              default: nxt_lim4 = source_operand;
            endcase
            if (instr[`MCBL_LDCA_RST_BIT]) begin
              nxt_clear[instr[`MCBL_LDCA_EOC_MSB:`MCBL_LDCA_EOC_LSB]] = 1'b1;
            end
            nxt_link_a = shortcut(output_link_a_ff, instr[`MCBL_SH1_MSB:`MCBL_SH1_LSB]);
            nxt_link_b = shortcut(output_link_b_ff, instr[`MCBL_SH2_MSB:`MCBL_SH2_LSB]);
          end else if (is_op(instr, `MCBL_LDCD_MASK, `MCBL_LDCD_PAT)) begin
            nxt_dram_rd = 1'b1;
            if (instr[`MCBL_LDCD_OFS_BIT]) begin
              nxt_dram_addr = dram_field + index_base;
            end else begin
              nxt_dram_addr = dram_field;
            end
            nxt_pend_eoc = instr[`MCBL_LDCD_EOC_MSB:`MCBL_LDCD_EOC_LSB];
            nxt_pend_rst = instr[`MCBL_LDCD_RST_BIT];
            nxt_link_a = shortcut(output_link_a_ff, instr[`MCBL_SH1_MSB:`MCBL_SH1_LSB]);
            nxt_link_b = shortcut(output_link_b_ff, instr[`MCBL_SH2_MSB:`MCBL_SH2_LSB]);
            nxt_stall = 1'b1;
            nxt_state = ST_WAIT;
          end else if (is_op(instr, `MCBL_LDIRH_MASK, `MCBL_LDIRH_PAT)) begin
            nxt_imm = {byte_operand, clr_other ? 8'h00 : immediate_word_ff[7:0]};
          end else if (is_op(instr, `MCBL_LDIRL_MASK, `MCBL_LDIRL_PAT)) begin
            nxt_imm = {clr_other ? 8'h00 : immediate_word_ff[15:8], byte_operand};
          end
        end
      end
      ST_WAIT: begin
        case (pend_eoc_ff)
          2'h0: nxt_lim1 = dram_rdata;
          2'h1: nxt_lim2 = dram_rdata;
          2'h2: nxt_lim3 = dram_rdata;
          default: nxt_lim4 = dram_rdata;
        endcase
        if (pend_rst_ff) begin
          nxt_clear[pend_eoc_ff] = 1'b1;
        end
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Status register port
  // --------------------------------------------------------------------------
  always @* begin
    case (reg_addr)
      `MCBL_CORE0_STATUS_A, `MCBL_CORE0_STATUS_B, `MCBL_CORE0_STATUS_C: begin
        nxt_rdata = status0_ff;
      end
      `MCBL_CORE1_STATUS_A, `MCBL_CORE1_STATUS_B, `MCBL_CORE1_STATUS_C: begin
        nxt_rdata = status1_ff;
      end
      default: begin
        nxt_rdata = {DATA_W{1'b0}};
      end
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      status0_ff <= `MCBL_STATUS_RESET;
      status1_ff <= `MCBL_STATUS_RESET;
      reg_rdata_ff <= {DATA_W{1'b0}};
    end else begin
      reg_rdata_ff <= nxt_rdata;
      if (reg_wr) begin
        case (reg_addr)
          `MCBL_CORE0_STATUS_A, `MCBL_CORE0_STATUS_B, `MCBL_CORE0_STATUS_C: begin
            status0_ff <= reg_wdata;
          end
          `MCBL_CORE1_STATUS_A, `MCBL_CORE1_STATUS_B, `MCBL_CORE1_STATUS_C: begin
            status1_ff <= reg_wdata;
          end
          default: begin
            status0_ff <= status0_ff;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Execution registers
  // --------------------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      pend_eoc_ff <= 2'h0;
      pend_rst_ff <= 1'b0;
      micro_program_counter_ff <= {PC_W{1'b0}};
      return_address_ff <= {PC_W{1'b0}};
      stall_ff <= 1'b0;
      dram_rd_ff <= 1'b0;
      dram_addr_ff <= {DRAM_W{1'b0}};
      count_limit_1_ff <= {DATA_W{1'b0}};
      count_limit_2_ff <= {DATA_W{1'b0}};
      count_limit_3_ff <= {DATA_W{1'b0}};
      count_limit_4_ff <= {DATA_W{1'b0}};
      count_clear_ff <= 4'h0;
      output_link_a_ff <= 1'b0;
      output_link_b_ff <= 1'b0;
      immediate_word_ff <= {DATA_W{1'b0}};
    end else begin
      state_ff <= nxt_state;
      pend_eoc_ff <= nxt_pend_eoc;
      pend_rst_ff <= nxt_pend_rst;
      micro_program_counter_ff <= nxt_pc;
      return_address_ff <= nxt_ret;
      stall_ff <= nxt_stall;
      dram_rd_ff <= nxt_dram_rd;
      dram_addr_ff <= nxt_dram_addr;
      count_limit_1_ff <= nxt_lim1;
      count_limit_2_ff <= nxt_lim2;
      count_limit_3_ff <= nxt_lim3;
      count_limit_4_ff <= nxt_lim4;
      count_clear_ff <= nxt_clear;
      output_link_a_ff <= nxt_link_a;
      output_link_b_ff <= nxt_link_b;
      immediate_word_ff <= nxt_imm;
    end
  end

endmodule

// ### verif/mcbl_exec_properties.sv
// Purpose: Port relations of the branch and load unit.
// Assumes: Instruction encodings of mcbl_consts.vh.
// Notes: Bound to every mcbl_exec instance.
`timescale 1ns/1ps
`include "mcbl_consts.vh"
module mcbl_props #(
  parameter PC_W = 10,
  parameter DATA_W = 16,
  parameter DRAM_W = 6
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Watched ports
  input wire instr_valid,
  input wire [15:0] instr,
  input wire stall_ff,
  input wire [PC_W-1:0] micro_program_counter_ff,
  input wire [PC_W-1:0] return_address_ff,
  input wire [PC_W-1:0] jump_target_reg_a,
  input wire [PC_W-1:0] jump_target_reg_b,
  input wire [DATA_W-1:0] source_operand,
  input wire [DRAM_W-1:0] index_base,
  input wire dram_rd_ff,
  input wire [DRAM_W-1:0] dram_addr_ff,
  input wire [DATA_W-1:0] count_limit_4_ff,
  input wire [3:0] count_clear_ff,
  input wire output_link_b_ff
);
  // --------------------------------------------------------------------------
  // Decode of taken instructions
  // --------------------------------------------------------------------------
  wire take = instr_valid && !stall_ff;
  wire far = take && ((instr & `MCBL_JTSF_MASK) == `MCBL_JTSF_PAT);
  wire rel = take && ((instr & `MCBL_JTSR_MASK) == `MCBL_JTSR_PAT);
  wire ldca = take && ((instr & `MCBL_LDCA_MASK) == `MCBL_LDCA_PAT);
  wire ldcd = take && ((instr & `MCBL_LDCD_MASK) == `MCBL_LDCD_PAT);
  wire [PC_W-1:0] far_pc = instr[3] ? jump_target_reg_b : jump_target_reg_a;
  wire [PC_W-1:0] rel_pc = micro_program_counter_ff + {{(PC_W-5){instr[4]}}, instr[4:0]};
  wire [DRAM_W-1:0] dr_a = instr[12] ? instr[7:2] + index_base : instr[7:2];
  wire [3:0] clr_x = instr[12] ? 4'h1 << instr[7:6] : 4'h0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_call_saves_pc: assert property (
    (far || rel) |=> return_address_ff == $past(micro_program_counter_ff)) else $error("ret");
  a_far_target: assert property (
    far |=> micro_program_counter_ff == $past(far_pc)) else $error("far call");
  a_rel_target: assert property (
    rel |=> micro_program_counter_ff == $past(rel_pc)) else $error("rel call");
  a_ldcd_stall: assert property (
    ldcd |=> stall_ff && dram_rd_ff ##1 !stall_ff && !dram_rd_ff) else $error("stall");
  a_dram_addr: assert property (
    ldcd |=> dram_addr_ff == $past(dr_a)) else $error("dram addr");
  a_limit_load: assert property (
    ldca && instr[7:6] == 2'h3 |=> count_limit_4_ff == $past(source_operand)) else $error("lim");
  a_clear_pulse: assert property (
    ldca |=> count_clear_ff == $past(clr_x)) else $error("clear");
  a_link_off: assert property (
    ldca && instr[9:8] == `MCBL_SC_OFF |=> !output_link_b_ff) else $error("link");
  c_ldcd_index: cover property (ldcd && instr[12]);
  c_far_call: cover property (far && instr[3]);
  c_ldca_clear: cover property (ldca && instr[12]);
endmodule
bind mcbl_exec mcbl_props #(.PC_W(PC_W), .DATA_W(DATA_W), .DRAM_W(DRAM_W)) u_props (
  .clk(clk), .reset(reset), .instr_valid(instr_valid), .instr(instr), .stall_ff(stall_ff),
  .micro_program_counter_ff(micro_program_counter_ff), .return_address_ff(return_address_ff),
  .jump_target_reg_a(jump_target_reg_a), .jump_target_reg_b(jump_target_reg_b),
  .source_operand(source_operand), .index_base(index_base), .dram_rd_ff(dram_rd_ff),
  .dram_addr_ff(dram_addr_ff), .count_limit_4_ff(count_limit_4_ff),
  .count_clear_ff(count_clear_ff), .output_link_b_ff(output_link_b_ff));

// ### verif/test_microcore_branch_load_ops.sv
// Purpose: Self-checking bench for the branch and load unit.
// Assumes: Inputs change on the falling clock edge.
// Notes: Expected values come from a small model kept in the bench.
`timescale 1ns/1ps
module test_microcore_branch_load_ops;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg vld = 1'b0;
  reg [15:0] ins = 16'h0000;
  reg csel = 1'b0;
  reg [15:0] src = 16'h0000;
  reg [15:0] rdat = 16'hFFFF;
  reg [8:0] ra = 9'h000;
  reg rwr = 1'b0;
  reg [15:0] wd = 16'h0000;
  wire stall, rd, lka, lkb;
  wire [9:0] pc_o, ret_o;
  wire [5:0] daddr;
  wire [15:0] l1, l2, l3, l4, imm, rdo;
  wire [3:0] clr;
  integer errors = 0;
  integer n_compared = 0;
  integer cycles = 0;
  integer i;
  reg [9:0] pc = 10'h000;
  reg [9:0] p;
  reg la = 1'b0;
  reg lb = 1'b0;
  reg [15:0] im = 16'h0000;
  reg [15:0] st;
  reg [7:0] v;
  reg [9:0] jra = 10'h2AA;
  reg [9:0] jrb = 10'h155;
  reg [5:0] ib = 6'h05;
  reg [5:0] a6;
  mcbl_exec dut_u (.clk(clk), .reset(reset), .instr_valid(vld), .instr(ins), .core_sel(csel),
    .stall_ff(stall), .micro_program_counter_ff(pc_o), .return_address_ff(ret_o),
    .jump_target_reg_a(jra), .jump_target_reg_b(jrb), .source_operand(src),
    .index_base(ib), .dram_rd_ff(rd), .dram_addr_ff(daddr), .dram_rdata(rdat),
    .count_limit_1_ff(l1), .count_limit_2_ff(l2), .count_limit_3_ff(l3), .count_limit_4_ff(l4),
    .count_clear_ff(clr), .output_link_a_ff(lka), .output_link_b_ff(lkb),
    .immediate_word_ff(imm), .reg_addr(ra), .reg_wr(rwr), .reg_wdata(wd), .reg_rdata_ff(rdo));
  always #20 clk = ~clk;
  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task stop_test;
    begin
      $display("Compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      errors = errors + 1;
      stop_test;
    end
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Holds the instruction valid; the caller drops it after its last issue.
  task issue(input [15:0] w, input [9:0] nxt);
    begin
      vld = 1'b1;
      ins = w;
      @(negedge clk);
      chk({6'h00, pc_o}, {6'h00, nxt});
      pc = nxt;
    end
  endtask
  task reg_rw(input [8:0] a, input [15:0] d, input [8:0] rda, input [15:0] exp);
    begin
      ra = a;
      wd = d;
      rwr = 1'b1;
      @(negedge clk);
      rwr = 1'b0;
      ra = rda;
      @(negedge clk);
      chk(rdo, exp);
    end
  endtask
  function sc(input cur, input [1:0] code);
    sc = (code == 2'h3) ? ~cur : (code == 2'h0) ? cur : code[1];
  endfunction
  function [15:0] lim(input [1:0] e);
    lim = (e == 2'h0) ? l1 : (e == 2'h1) ? l2 : (e == 2'h2) ? l3 : l4;
  endfunction
  initial begin
    repeat (3) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    reg_rw(9'h105, 16'hA5C3, 9'h145, 16'hA5C3);
    reg_rw(9'h126, 16'h3C5A, 9'h106, 16'h3C5A);
    reg_rw(9'h107, 16'hFFFF, 9'h125, 16'hA5C3);
    reg_rw(9'h107, 16'h1234, 9'h107, 16'h0000);
    for (i = 0; i < 64; i = i + 1) begin
      csel = i[5];
      st = i[5] ? 16'h3C5A : 16'hA5C3;
      p = i[0] ? 10'h3F0 : 10'h00F;
      issue(16'h3000 | {i[0], i[4:1], p[4:0]}, (st[i[4:1]] == i[0]) ? pc + p : pc + 10'h001);
    end
    for (i = 0; i < 8; i = i + 1) begin
      p = pc;
      jra = i[2] ? 10'h3E1 : 10'h2AA;
      jrb = i[2] ? 10'h01E : 10'h155;
      if (i[1:0] == 2'h0) issue(16'h39B5, jra);
      else if (i[1:0] == 2'h1) issue(16'h39BD, jrb);
      else if (i[1:0] == 2'h2) issue(16'h2F30, p - 10'h010);
      else issue(16'h2F2F, p + 10'h00F);
      chk({6'h00, ret_o}, {6'h00, p});
    end
    for (i = 0; i < 8; i = i + 1) begin
      src = 16'h9E00 + i[15:0];
      la = sc(la, i[1:0]);
      lb = sc(lb, ~i[1:0]);
      issue(16'hA004 | {i[0], i[1:0], ~i[1:0], i[1:0], 6'h00}, pc + 10'h001);
      chk(lim(i[1:0]), src);
      chk({12'h000, clr}, i[0] ? (16'h0001 << i[1:0]) : 16'h0000);
      chk({14'h0000, lka, lkb}, {14'h0000, la, lb});
    end
    for (i = 0; i < 4; i = i + 1) begin
      ib = i[1] ? 6'h2A : 6'h05;
      a6 = i[1] ? 6'h3F + ib : 6'h3F;
      la = ~la;
      lb = ~lb;
      issue(16'hC000 | {i[0], i[1], 4'hF, 6'h3F, i[1:0]}, pc + 10'h001);
      // A low-byte load held through the stall cycle must be ignored.
      ins = 16'h3BFE;
      chk({10'h000, daddr}, {10'h000, a6});
      chk({14'h0000, stall, rd}, 16'h0003);
      chk({14'h0000, lka, lkb}, {14'h0000, la, lb});
      rdat = 16'h6D00 + i[15:0];
      @(negedge clk);
      rdat = ~rdat;
      chk(lim(i[1:0]), 16'h6D00 + i[15:0]);
      chk({12'h000, clr}, i[0] ? (16'h0001 << i[1:0]) : 16'h0000);
      chk({6'h00, pc_o}, {6'h00, pc});
      chk(imm, 16'h0000);
    end
    for (i = 0; i < 4; i = i + 1) begin
      v = 8'hA5 ^ i[7:0];
      if (i[0]) im = {v, i[1] ? 8'h00 : im[7:0]};
      else im = {i[1] ? 8'h00 : im[15:8], v};
      issue({5'h07, i[1], v, 1'b1, i[0]}, pc + 10'h001);
      chk(imm, im);
    end
    vld = 1'b0;
    @(negedge clk);
    stop_test;
  end
endmodule
